// ===== spm_params.svh
`ifndef SPM_PARAMS_SVH
`define SPM_PARAMS_SVH
// register indices; the apb byte address is the index times four
`define SPM_REG_CTRL 10'h270
`define SPM_REG_PERIOD_LO 10'h271
`define SPM_REG_PERIOD_MID 10'h272
`define SPM_REG_PERIOD_HI 10'h273
`define SPM_REG_HOLD_LO 10'h274
`define SPM_REG_HOLD_HI 10'h275
`define SPM_REG_SERIAL_STATISTICS_OUTPUT_A 10'h279
`define SPM_REG_SERIAL_STATISTICS_OUTPUT_B 10'h27a
`define SPM_REG_TAIL 10'h27b
`define SPM_REG_STATUS 10'h27c
// field positions
`define SPM_CTRL_PEAK_EN_BIT 1
`define SPM_SERIAL_STATISTICS_OUTPUT_B_EN_BIT 1
`define SPM_TAIL_PRBS_BIT 0
`define SPM_TAIL_CS_LSB 4
// reset values
`define SPM_PERIOD_RST 24'h000050
`define SPM_CS_RST 2'h1
`define SPM_PRBS_SEED 15'h7fff
// frame layout
`define SPM_FRAME_BITS 25
`define SPM_SUB_BITS 5
`define SPM_FRAME_CNT_W 5
`endif

// ===== spm_pkg.sv
package spm_pkg;
  // states of the peak tracker
  typedef enum logic [2:0] {
    SPM_IDLE = 3'b001,
    SPM_FIRST = 3'b010,
    SPM_TRACK = 3'b100
  } spm_state_type;
endpackage

// ===== spm_serial_statistics_output_ser.sv
`timescale 1ns/1ps
`default_nettype none
`include "spm_params.svh"
// serialises a 13-bit peak into a 25-bit frame of five 5-bit subframes
module spm_serial_statistics_output_ser (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic sample_en,
  input wire logic run,
  input wire logic [12:0] peak,
  input wire logic peak_new,
  // serial bit out
  output logic ser_bit
);
  logic [24:0] shift_q, shift_d;
  logic [4:0] cnt_q, cnt_d;
  logic pend_q, pend_d;
  logic [12:0] pend_val_q, pend_val_d;
  logic [24:0] frame;

  // each subframe: start bit 1 then four payload bits, msb first; 4 data nibbles
  // hold 13 bits padded with three leading zeros in the first subframe
  assign frame = {1'b1, 3'b000, peak_src_msb(pend_val_q),
                  1'b1, pend_val_q[11:8], 1'b1, pend_val_q[7:4],
                  1'b1, pend_val_q[3:0], 1'b1, 4'h0};

  function automatic logic peak_src_msb(input logic [12:0] v);
    peak_src_msb = v[12];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // frame sequencing: a held value is sent whole before the next starts
  always_comb begin
    shift_d = shift_q;
    cnt_d = cnt_q;
    pend_d = pend_q;
    pend_val_d = pend_val_q;
    if (peak_new && run) begin
      pend_d = 1'b1;
      pend_val_d = peak;
    end
    if (!run) begin
      cnt_d = 5'h00;
      pend_d = 1'b0;
    end else if (sample_en) begin
      if (cnt_q != 5'h00) begin
        shift_d = {shift_q[23:0], 1'b0};
        cnt_d = cnt_q - 5'h01;
      end else if (pend_q && !(peak_new && run)) begin
        shift_d = frame;
        cnt_d = 5'(`SPM_FRAME_BITS);
        pend_d = 1'b0;
      end else begin
        shift_d = 25'h0000000; // idle line stays low between frames
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q <= 25'h0000000;
      cnt_q <= 5'h00;
      pend_q <= 1'b0;
      pend_val_q <= 13'h0000;
    end else begin
      shift_q <= shift_d;
      cnt_q <= cnt_d;
      pend_q <= pend_d;
      pend_val_q <= pend_val_d;
    end
  end

  assign ser_bit = (cnt_q != 5'h00) ? shift_q[24] : 1'b0;
endmodule
`default_nettype wire

// ===== spm_monitor.sv
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "spm_params.svh"
//
// Contract
// - track magnitude only, 13-bit peak
// - 24-bit period counted in samples
// - control bit 1 enables peak detection
// - enable loads timer, decrements per sample
// - keep larger of input and store
// - measurement starts from current magnitude
// - at count one, copy peak to holding
// - reload timer, restart from next sample
// - results by readback and control bits
// - serial output needs both enable fields
// - control bits fill from msb down
// - 25-bit frame, msb first, five subframes
// - control bits per sample 0 to 3
// - tail bits are n' minus n minus cs
// - 14-bit sample packs into two octets
// - unused tail bits zero or pseudorandom
//
module spm_monitor (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // decimated sample stream, same clock
  input wire logic sample_en,
  input wire logic [13:0] sample,
  // link sample word out
  output logic [15:0] link_word,
  output logic link_valid
);
  import spm_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // register storage
  // each register is one aligned 32-bit word; only the low byte is live
  // the 24-bit period is split over three byte registers, low first
  // hazard: the period bytes are written one at a time, so a host that
  // changes the period while tracking runs may reload a mixed value;
  // the tracker only takes the period at enable and at each reload
  // the holding register is read-only and changes only at period end
  // the status flag is sticky and cleared by writing a one to bit 0
  logic peak_en_q, peak_en_d;
  logic [23:0] period_q, period_d;
  logic [1:0] serial_statistics_output_a_q, serial_statistics_output_a_d;
  logic serial_statistics_output_b_q, serial_statistics_output_b_d;
  logic prbs_sel_q, prbs_sel_d;
  logic [1:0] cs_q, cs_d;
  logic [12:0] hold_q, hold_d;
  logic hold_new_q, hold_new_d;
  logic done_q, done_d;
  logic acc;
  logic wr;
  logic addr_ok;
  logic [9:0] reg_idx;
  logic aligned;

  // word index from the byte address; a misaligned access hits nothing
  assign reg_idx = paddr[11:2];
  assign aligned = (paddr[1:0] == 2'b00);
  assign acc = psel && penable;
  assign wr = acc && pwrite && aligned;
  assign pready = 1'b1; // zero wait states

  // known addresses; anything else answers slverr
  always_comb begin
    case (reg_idx)
      `SPM_REG_CTRL, `SPM_REG_PERIOD_LO, `SPM_REG_PERIOD_MID, `SPM_REG_PERIOD_HI,
      `SPM_REG_HOLD_LO, `SPM_REG_HOLD_HI, `SPM_REG_SERIAL_STATISTICS_OUTPUT_A, `SPM_REG_SERIAL_STATISTICS_OUTPUT_B,
      `SPM_REG_TAIL, `SPM_REG_STATUS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pslverr = acc && !(addr_ok && aligned);

  // readback mux; holding register is read-only
  always_comb begin
    prdata = 32'h00000000;
    case (reg_idx)
      `SPM_REG_CTRL: prdata[`SPM_CTRL_PEAK_EN_BIT] = peak_en_q;
      `SPM_REG_PERIOD_LO: prdata[7:0] = period_q[7:0];
      `SPM_REG_PERIOD_MID: prdata[7:0] = period_q[15:8];
      `SPM_REG_PERIOD_HI: prdata[7:0] = period_q[23:16];
      `SPM_REG_HOLD_LO: prdata[7:0] = hold_q[7:0];
      `SPM_REG_HOLD_HI: prdata[4:0] = hold_q[12:8];
      `SPM_REG_SERIAL_STATISTICS_OUTPUT_A: prdata[1:0] = serial_statistics_output_a_q;
      `SPM_REG_SERIAL_STATISTICS_OUTPUT_B: prdata[`SPM_SERIAL_STATISTICS_OUTPUT_B_EN_BIT] = serial_statistics_output_b_q;
      `SPM_REG_TAIL: begin
        prdata[`SPM_TAIL_PRBS_BIT] = prbs_sel_q;
        prdata[`SPM_TAIL_CS_LSB +: 2] = cs_q;
      end
      `SPM_REG_STATUS: prdata[0] = done_q;
      default: prdata = 32'h00000000;
    endcase
    if (!aligned)
      prdata = 32'h00000000;
  end

  ////////////////////////////////////////////////////////////////////////
  // peak tracker state
  // idle: detection off, nothing counts; first: the next sample seeds the
  // running store; track: every sample keeps the larger magnitude
  // the running store is private; software only sees the holding copy
  // trade-off: the store is seeded from the sample itself rather than zero,
  // so a quiet period reports its true level and not a stale peak
  // limitation: switching detection off drops the period in progress;
  // the holding register keeps the last complete result
  // the timer counts samples, not clocks, so gaps in the stream only
  // stretch a period in time and never shorten it in samples
  spm_state_type st_q, st_d;
  logic [23:0] timer_q, timer_d;
  logic [12:0] store_q, store_d;
  logic [12:0] mag;
  logic [13:0] mag_full;

  // magnitude of two's complement sample, saturated into 13 bits
  // the most negative code has no positive twin in 13 bits, so it
  // clips to full scale instead of wrapping to zero
  always_comb begin
    mag_full = sample[13] ? 14'(~sample + 14'h0001) : sample;
    mag = mag_full[13] ? 13'h1fff : mag_full[12:0];
  end

  // control registers next values
  always_comb begin
    peak_en_d = peak_en_q;
    period_d = period_q;
    serial_statistics_output_a_d = serial_statistics_output_a_q;
    serial_statistics_output_b_d = serial_statistics_output_b_q;
    prbs_sel_d = prbs_sel_q;
    cs_d = cs_q;
    if (wr) begin
      case (reg_idx)
        `SPM_REG_CTRL: peak_en_d = pwdata[`SPM_CTRL_PEAK_EN_BIT];
        `SPM_REG_PERIOD_LO: period_d[7:0] = pwdata[7:0];
        `SPM_REG_PERIOD_MID: period_d[15:8] = pwdata[7:0];
        `SPM_REG_PERIOD_HI: period_d[23:16] = pwdata[7:0];
        `SPM_REG_SERIAL_STATISTICS_OUTPUT_A: serial_statistics_output_a_d = pwdata[1:0];
        `SPM_REG_SERIAL_STATISTICS_OUTPUT_B: serial_statistics_output_b_d = pwdata[`SPM_SERIAL_STATISTICS_OUTPUT_B_EN_BIT];
        `SPM_REG_TAIL: begin
          prbs_sel_d = pwdata[`SPM_TAIL_PRBS_BIT];
          cs_d = pwdata[`SPM_TAIL_CS_LSB +: 2];
        end
        default: ;
      endcase
    end
  end

  // tracker next values; period of 0 is treated like 1
  // a period of p gives one holding update every p samples: the seeding
  // sample counts as the first, and the sample that meets a count of one
  // still takes part in the comparison before the copy is made
  // the sample after a copy seeds the next period, so periods run back
  // to back with no sample lost between them
  // the done flag is set on every copy; a clear in the same cycle loses
  always_comb begin
    st_d = st_q;
    timer_d = timer_q;
    store_d = store_q;
    hold_d = hold_q;
    hold_new_d = 1'b0;
    done_d = done_q;
    if (wr && reg_idx == `SPM_REG_STATUS && pwdata[0])
      done_d = 1'b0;
    case (st_q)
      SPM_IDLE: begin
        if (peak_en_q) begin
          timer_d = period_q;
          st_d = SPM_FIRST;
        end
      end
      SPM_FIRST: begin
        if (!peak_en_q) begin
          st_d = SPM_IDLE;
        end else if (sample_en) begin
          store_d = mag;
          if (timer_q <= 24'h000001) begin
            hold_d = mag;
            hold_new_d = 1'b1;
            done_d = 1'b1;
            timer_d = period_q;
          end else begin
            timer_d = timer_q - 24'h000001;
            st_d = SPM_TRACK;
          end
        end
      end
      SPM_TRACK: begin
        if (!peak_en_q) begin
          st_d = SPM_IDLE;
        end else if (sample_en) begin
          if (timer_q <= 24'h000001) begin
            hold_d = (mag > store_q) ? mag : store_q;
            hold_new_d = 1'b1;
            done_d = 1'b1; // set wins over clear
            timer_d = period_q;
            st_d = SPM_FIRST;
          end else begin
            store_d = (mag > store_q) ? mag : store_q;
            timer_d = timer_q - 24'h000001;
          end
        end
      end
      default: st_d = SPM_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peak_en_q <= 1'b0;
      period_q <= `SPM_PERIOD_RST;
      serial_statistics_output_a_q <= 2'h0;
      serial_statistics_output_b_q <= 1'b0;
      prbs_sel_q <= 1'b0;
      cs_q <= `SPM_CS_RST;
      st_q <= SPM_IDLE;
      timer_q <= 24'h000000;
      store_q <= 13'h0000;
      hold_q <= 13'h0000;
      hold_new_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      peak_en_q <= peak_en_d;
      period_q <= period_d;
      serial_statistics_output_a_q <= serial_statistics_output_a_d;
      serial_statistics_output_b_q <= serial_statistics_output_b_d;
      prbs_sel_q <= prbs_sel_d;
      cs_q <= cs_d;
      st_q <= st_d;
      timer_q <= timer_d;
      store_q <= store_d;
      hold_q <= hold_d;
      hold_new_q <= hold_new_d;
      done_q <= done_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial statistics output over control bits
  // both enable fields must be set; either one clear stops the line and
  // drops a frame in flight, so the receiver must rehunt a start bit
  // the serialiser takes one bit per sample plus one sample to load, so a frame needs 26 samples;
  // periods shorter than that leave only the newest pending value queued
  // routing the control bits onto the lanes is left to the host's
  // link settings, which live outside this block
  logic serial_statistics_output_run;
  logic ser_bit;
  assign serial_statistics_output_run = (serial_statistics_output_a_q == 2'h3) && serial_statistics_output_b_q;

  spm_serial_statistics_output_ser u_ser (
    .pclk(pclk),
    .presetn(presetn),
    .sample_en(sample_en),
    .run(serial_statistics_output_run),
    .peak(hold_q),
    .peak_new(hold_new_q),
    .ser_bit(ser_bit)
  );

  ////////////////////////////////////////////////////////////////////////
  // tail prbs, x^15 + x^14 + 1, advanced once per sample
  // runs whether or not it is selected, so turning it on mid-stream
  // does not restart the sequence; the seed is nonzero to avoid lock-up
  logic [14:0] prbs_q, prbs_d;
  always_comb begin
    prbs_d = prbs_q;
    if (sample_en)
      prbs_d = {prbs_q[13:0], prbs_q[14] ^ prbs_q[13]};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prbs_q <= `SPM_PRBS_SEED;
    else
      prbs_q <= prbs_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // sample word packing: 14 data bits then two low bits for control or tail
  // the sample sits in the top 14 bits so the two octets split as
  // bits 13..6 and bits 5..0 plus the two low slots
  // control bits take the low slots from the top down; what is left over
  // is tail, either zeros or the prbs, as selected in the tail register
  // the word is registered so it stands whole until the next sample
  // with n'=16, n=14 there are only two low slots; cs=3 loses its third bit
  logic [1:0] low_bits;
  logic [1:0] tail_fill;
  logic [15:0] word_d, word_q;
  logic valid_q;
  assign tail_fill = prbs_sel_q ? prbs_q[1:0] : 2'b00;
  always_comb begin
    case (cs_q)
      2'h0: low_bits = tail_fill;
      2'h1: low_bits = {ser_bit, tail_fill[0]};
      default: low_bits = {ser_bit, 1'b0};
    endcase
    word_d = {sample, low_bits};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_q <= 16'h0000;
      valid_q <= 1'b0;
    end else begin
      word_q <= sample_en ? word_d : word_q;
      valid_q <= sample_en;
    end
  end
  assign link_word = word_q;
  assign link_valid = valid_q;
endmodule
`default_nettype wire

// ===== spm_monitor_chk.sv
`timescale 1ns/1ps
`default_nettype none
module spm_monitor_chk (
  // apb side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // sample stream and link word
  input wire logic sample_en,
  input wire logic [13:0] sample,
  input wire logic [15:0] link_word,
  input wire logic link_valid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mapped;
  logic acc;
  logic [9:0] idx;
  // decode kept apart so the properties stay short; word index is paddr / 4
  assign idx = paddr[11:2];
  assign mapped = (paddr[1:0] == 2'b00) &&
    ((idx >= 10'h270 && idx <= 10'h275) || (idx >= 10'h279 && idx <= 10'h27c));
  assign acc = psel && penable;
  ////////////////////////////////////////////////////////////////
  valid_follows_a: assert property (sample_en |=> link_valid)
    else $error("link_valid missing after sample");
  valid_cause_a: assert property (!sample_en |=> !link_valid)
    else $error("link_valid without sample");
  word_sample_a: assert property (sample_en |=> link_word[15:2] == $past(sample))
    else $error("link word sample bits wrong");
  word_hold_a: assert property (!sample_en |=> $stable(link_word))
    else $error("link word moved between samples");
  ready_high_a: assert property (acc |-> pready)
    else $error("pready low in access");
  unmapped_err_a: assert property (acc && !mapped |-> pslverr)
    else $error("no error on unmapped access");
  mapped_ok_a: assert property (acc && mapped |-> !pslverr)
    else $error("error on mapped access");
  err_access_a: assert property (!acc |-> !pslverr)
    else $error("pslverr outside access");
  unmapped_zero_a: assert property (acc && !mapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  // main scenarios
  cover property (acc && !mapped);
  cover property (sample_en ##1 sample_en);
  cover property (link_valid && link_word[1]);
endmodule
bind spm_monitor spm_monitor_chk chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sample_en(sample_en), .sample(sample), .link_word(link_word), .link_valid(link_valid)
);
`default_nettype wire

// ===== spm_link_rx.sv
`timescale 1ns/1ps
`default_nettype none
module spm_link_rx (
  // link side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic link_valid,
  input wire logic [15:0] link_word,
  // recovered frames
  output logic [12:0] rx_peak,
  output logic [7:0] rx_frames,
  output logic [7:0] rx_bad
);
  logic [24:0] sh;
  int n;
  // hunt a start bit in the top control slot, then take 25 bits
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n = 0;
      rx_frames <= 8'h0;
      rx_bad <= 8'h0;
      rx_peak <= 13'h0;
    end else if (link_valid && (n > 0 || link_word[1] === 1'b1)) begin
      sh = {sh[23:0], link_word[1]};
      n = n + 1;
      if (n == 25) begin
        n = 0;
        rx_frames <= rx_frames + 8'h1;
        rx_peak <= {sh[20], sh[18:15], sh[13:10], sh[8:5]};
        // start and pad bits catch a slipped frame
        if ({sh[24], sh[19], sh[14], sh[9], sh[4]} !== 5'h1f || |sh[23:21] || |sh[3:0])
          rx_bad <= rx_bad + 8'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== test_signal_peak_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module test_signal_peak_monitor;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic sample_en, link_valid;
  logic [13:0] sample, x;
  logic [15:0] link_word;
  logic [12:0] rx_peak;
  logic [12:0] expv [4];
  logic [7:0] rx_frames, rx_bad;
  logic [11:0] ra [7] = '{12'h270, 12'h271, 12'h272, 12'h273, 12'h274, 12'h275, 12'h27b};
  logic [7:0] rv [7] = '{8'h0, 8'h50, 8'h0, 8'h0, 8'h0, 8'h0, 8'h10};
  int fails = 0;
  int num_checks = 0;
  int seed = 32'h98fd3a66;
  spm_monitor dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_en(sample_en), .sample(sample), .link_word(link_word),
    .link_valid(link_valid));
  spm_link_rx rx (.pclk(pclk), .presetn(presetn), .link_valid(link_valid),
    .link_word(link_word), .rx_peak(rx_peak), .rx_frames(rx_frames), .rx_bad(rx_bad));
  ////////////////////////////////////////////////////////////////
  // 125 mhz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {a[9:0], 2'b00}; // byte address is four times the index
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 64);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (t >= 64) begin
      fails++;
      $display("[ERR] %0t apb timeout", $time);
    end
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk({rerr, rdata}, {25'h0, e});
  endtask
  // random gap keeps some samples back to back
  task automatic smp(input logic [13:0] v);
    sample <= v;
    sample_en <= 1'b1;
    @(posedge pclk);
    if ($random(seed) & 1) begin
      sample_en <= 1'b0;
      @(posedge pclk);
    end
  endtask
  function automatic logic [12:0] mag(input logic [13:0] v);
    logic [13:0] n;
    n = v[13] ? -v : v;
    return n[13] ? 13'h1fff : n[12:0];
  endfunction
  ////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    sample_en = 1'b0;
    sample = 14'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 7; i++) rd(ra[i], rv[i]);
    apb(1'b1, 12'h276, 32'hff);
    chk({32'h0, rerr}, 33'h1);
    apb(1'b0, 12'h276, 32'h0);
    chk({rerr, rdata}, {1'b1, 32'h0});
    apb(1'b1, 12'h271, 32'h1e);
    apb(1'b1, 12'h272, 32'h0);
    apb(1'b1, 12'h273, 32'h0);
    rd(12'h271, 8'h1e);
    apb(1'b1, 12'h279, 32'h3);
    apb(1'b1, 12'h27a, 32'h2);
    repeat (5) smp(14'h1fff);
    sample_en <= 1'b0;
    @(posedge pclk);
    rd(12'h274, 8'h0);
    apb(1'b1, 12'h270, 32'h2);
    for (int k = 0; k < 4; k++) begin
      expv[k] = 13'h0;
      for (int i = 0; i < 30; i++) begin
        x = 14'($random(seed));
        if (k == 2) x = (i == 0) ? 14'h3f00 : {{8{x[5]}}, x[5:0]};
        if (k == 0 && i == 3) x = 14'h2000;
        if (mag(x) > expv[k]) expv[k] = mag(x);
        smp(x);
      end
      sample_en <= 1'b0;
      @(posedge pclk);
      rd(12'h274, expv[k][7:0]);
      rd(12'h275, {3'h0, expv[k][12:8]});
      if (k > 0) chk({20'h0, rx_peak}, {20'h0, expv[k-1]});
      if (k == 0) begin
        rd(12'h27c, 8'h1);
        apb(1'b1, 12'h27c, 32'h1);
        rd(12'h27c, 8'h0);
      end
    end
    apb(1'b1, 12'h27b, 32'h21);
    rd(12'h27b, 8'h21);
    chk({17'h0, rx_bad, rx_frames}, {25'h0, 8'h3});
    tally_and_finish();
  end
endmodule
`default_nettype wire
